// >>> core/eei_pkg.sv
package eei_pkg;
    // protocol states of the serial front end
    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_RX = 3'h1,
        ST_ACK = 3'h2,
        ST_TX = 3'h3,
        ST_RXACK = 3'h4,
        ST_BUSY = 3'h5
    } eei_state_t;

    // what a received byte was taken as
    typedef enum logic [1:0] {
        KIND_SELECT = 2'h0,
        KIND_ADDR_HI = 2'h1,
        KIND_ADDR_LO = 2'h2,
        KIND_DATA = 2'h3
    } eei_kind_t;

    // one received byte as reported to the user side
    typedef struct packed {
        logic valid;
        eei_kind_t kind;
        logic idpage;
        logic [7:0] data;
    } eei_rx_t;

    // select byte layout
    localparam int SEL_TYPE_MSB = 7;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CS_MSB = 3;
    localparam int SEL_CS_LSB = 1;
    localparam int SEL_RW_BIT = 0;
    localparam logic SEL_RW_READ = 1'b1;

    // bit counting within a byte
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_STOP_SLOT = 4'h1;

    // synchroniser lanes
    localparam int SYN_SCL = 0;
    localparam int SYN_SDA = 1;
    localparam int SYN_CS0 = 2;
    localparam int SYN_CS1 = 3;
    localparam int SYN_CS2 = 4;
    localparam int SYN_WI = 5;
    localparam int SYN_TGL = 6;
    localparam int SYN_W = 7;

    // reset values
    localparam logic [SYN_W-1:0] SYN_RST = 7'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic OE_N_RST = 1'b1;
    localparam logic SDA_LOW = 1'b0;
    localparam eei_rx_t RX_RST = '{valid: 1'b0, kind: KIND_SELECT, idpage: 1'b0, data: 8'h00};
endpackage : eei_pkg

// >>> core/eei_slave_front_end.sv
`timescale 1ns/1ps
module eei_slave_front_end #(
    parameter logic [3:0] ARRAY_TYPE_ID = 4'h5, // arbitrary value
    parameter logic [3:0] IDPAGE_TYPE_ID = 4'h9, // arbitrary value
    parameter logic IDPAGE_EN = 1'b1 // second identifier accepted
) (
    input wire logic REF_CLK_I, // system clock
    input wire logic RESET_I, // power-on reset, sync, high
    input wire logic CE_I, // clock enable
    input wire logic SCL_I, // serial clock, link clock
    input wire logic SDA_I, // serial data level on the wire
    output logic SDA_O, // serial data drive value
    output logic SDA_OE_N_O, // low while pulling data low
    input wire logic CHIP_SELECT_STRAP_2_I, // strap for select bit 3
    input wire logic CHIP_SELECT_STRAP_1_I, // strap for select bit 2
    input wire logic CHIP_SELECT_STRAP_0_I, // strap for select bit 1
    input wire logic WRITE_INHIBIT_I, // high blocks writes
    input wire logic WR_BUSY_I, // internal write cycle running
    input wire logic [7:0] RD_DATA_I, // next byte to send
    output logic RD_NEXT_O, // pulse: read byte taken
    output eei_pkg::eei_rx_t RX_O, // received byte report
    output logic WRITE_START_O, // pulse: launch write cycle
    output logic STANDBY_O // device idle
);
    eei_pkg::eei_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic rw_reg;
    logic ack_reg;
    logic ack_phase_reg;
    logic slot_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [eei_pkg::SYN_W-1:0] async_in;
    logic [eei_pkg::SYN_W-1:0] sync1_reg;
    logic [eei_pkg::SYN_W-1:0] sync2_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic tgl_prev_reg;
    // link-domain flops: the serial clock may stand still, so they start from
    // a declared value instead of a reset that would need clock edges
    logic cap_reg = 1'b0;
    logic tgl_reg = 1'b0;
    logic scl_s;
    logic sda_s;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic [7:0] rx_byte;
    logic type_ok;
    logic cs_ok;
    logic idpage_hit;

    // link domain: sample data on every rising serial clock edge and flag it;
    // these flops ignore the clock enable, so the enable must stay high for
    // a whole frame or toggles are lost and the bit count slips
    always_ff @(posedge SCL_I)
    begin
        cap_reg <= SDA_I;
        tgl_reg <= ~tgl_reg;
    end

    // pins and the link toggle enter the system domain through two flops;
    // straps and inhibit are slow levels, so a plain two-flop chain suffices
    assign async_in = {tgl_reg, WRITE_INHIBIT_I, CHIP_SELECT_STRAP_2_I,
        CHIP_SELECT_STRAP_1_I, CHIP_SELECT_STRAP_0_I, SDA_I, SCL_I};

    for (genvar g = 0; g < eei_pkg::SYN_W; g++)
    begin : g_sync
        always_ff @(posedge REF_CLK_I)
        begin
            if (RESET_I)
            begin
                sync1_reg[g] <= eei_pkg::SYN_RST[g];
                sync2_reg[g] <= eei_pkg::SYN_RST[g];
            end
            else if (CE_I)
            begin
                sync1_reg[g] <= async_in[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end

    // previous synchronised levels for edge detection; clock and data both
    // leave reset low and rise together, so no false start or stop follows
    // previous synchronised levels for edge detection
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            scl_prev_reg <= 1'b0;
            sda_prev_reg <= 1'b0;
            tgl_prev_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            scl_prev_reg <= sync2_reg[eei_pkg::SYN_SCL];
            sda_prev_reg <= sync2_reg[eei_pkg::SYN_SDA];
            tgl_prev_reg <= sync2_reg[eei_pkg::SYN_TGL];
        end
    end

    // bus events; the master keeps data still while the clock is high,
    // so any data edge seen with the clock high is a start or a stop
    assign scl_s = sync2_reg[eei_pkg::SYN_SCL];
    assign sda_s = sync2_reg[eei_pkg::SYN_SDA];
    assign scl_fall = scl_prev_reg & ~scl_s;
    assign start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_ev = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    // cap_reg is held until the next serial rise, far longer than the
    // toggle's two-flop delay, so it is stable when the event is seen
    assign bit_ev = sync2_reg[eei_pkg::SYN_TGL] ^ tgl_prev_reg;

    // the byte as it stands once the current bit is shifted in, msb first
    assign rx_byte = {shift_reg[6:0], cap_reg};
    // the second identifier only counts where the extra page is fitted
    assign idpage_hit = IDPAGE_EN
        && (rx_byte[eei_pkg::SEL_TYPE_MSB:eei_pkg::SEL_TYPE_LSB] == IDPAGE_TYPE_ID);
    assign type_ok = idpage_hit
        || (rx_byte[eei_pkg::SEL_TYPE_MSB:eei_pkg::SEL_TYPE_LSB] == ARRAY_TYPE_ID);
    // a floating strap is pulled to zero at the pin, so it compares as zero
    assign cs_ok = rx_byte[eei_pkg::SEL_CS_MSB:eei_pkg::SEL_CS_LSB]
        == {sync2_reg[eei_pkg::SYN_CS2], sync2_reg[eei_pkg::SYN_CS1],
            sync2_reg[eei_pkg::SYN_CS0]};

    // protocol engine: the master supplies every clock, the device only follows;
    // the busy state is tested first, so nothing on the bus is decoded then
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            state_reg <= eei_pkg::ST_STANDBY;
            bit_cnt_reg <= eei_pkg::BIT_CNT_RST;
            byte_idx_reg <= 2'h0;
            rw_reg <= 1'b0;
            ack_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
            slot_reg <= 1'b0;
            shift_reg <= eei_pkg::BYTE_RST;
            tx_reg <= eei_pkg::BYTE_RST;
            SDA_OE_N_O <= eei_pkg::OE_N_RST;
            RX_O <= eei_pkg::RX_RST;
            RD_NEXT_O <= 1'b0;
            WRITE_START_O <= 1'b0;
        end
        else if (CE_I)
        begin
            RX_O.valid <= 1'b0;
            RD_NEXT_O <= 1'b0;
            WRITE_START_O <= 1'b0;
            if (state_reg == eei_pkg::ST_BUSY)
            begin
                // write running: pin released, start and select ignored
                SDA_OE_N_O <= eei_pkg::OE_N_RST;
                // busy answers one cycle after the launch pulse, so wait for it
                if (!WR_BUSY_I && !WRITE_START_O)
                    state_reg <= eei_pkg::ST_STANDBY;
            end
            else if (start_ev)
            begin
                state_reg <= eei_pkg::ST_RX;
                bit_cnt_reg <= eei_pkg::BIT_CNT_RST;
                byte_idx_reg <= 2'h0;
                slot_reg <= 1'b0;
                SDA_OE_N_O <= eei_pkg::OE_N_RST;
            end
            else if (stop_ev)
            begin
                SDA_OE_N_O <= eei_pkg::OE_N_RST;
                slot_reg <= 1'b0;
                // only a stop right after an acked data byte writes; a later
                // stop belongs to a byte that was cut short and is dropped
                if (slot_reg && state_reg == eei_pkg::ST_RX
                    && bit_cnt_reg <= eei_pkg::BIT_STOP_SLOT)
                begin
                    WRITE_START_O <= 1'b1;
                    state_reg <= eei_pkg::ST_BUSY;
                end
                else
                begin
                    state_reg <= eei_pkg::ST_STANDBY;
                end
            end
            else
            begin
                case (state_reg)
                    // receiving: shift bits in until eight have arrived
                    eei_pkg::ST_RX:
                    begin
                        if (bit_ev)
                        begin
                            shift_reg <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            // the write slot lasts only up to the tenth pulse
                            if (bit_cnt_reg != eei_pkg::BIT_CNT_RST)
                                slot_reg <= 1'b0;
                            if (bit_cnt_reg == eei_pkg::BIT_LAST)
                            begin
                                bit_cnt_reg <= eei_pkg::BIT_CNT_RST;
                                ack_phase_reg <= 1'b0;
                                RX_O.valid <= 1'b1;
                                RX_O.data <= rx_byte;
                                RX_O.kind <= eei_pkg::eei_kind_t'(byte_idx_reg);
                                if (byte_idx_reg == 2'h0)
                                begin
                                    RX_O.idpage <= idpage_hit;
                                    if (type_ok && cs_ok)
                                    begin
                                        ack_reg <= 1'b1;
                                        rw_reg <= rx_byte[eei_pkg::SEL_RW_BIT];
                                        state_reg <= eei_pkg::ST_ACK;
                                        if (rx_byte[eei_pkg::SEL_RW_BIT] == eei_pkg::SEL_RW_READ)
                                        begin
                                            tx_reg <= RD_DATA_I;
                                            RD_NEXT_O <= 1'b1;
                                        end
                                    end
                                    else
                                    begin
                                        state_reg <= eei_pkg::ST_STANDBY;
                                    end
                                end
                                else if (byte_idx_reg != 2'h3)
                                begin
                                    ack_reg <= 1'b1;
                                    state_reg <= eei_pkg::ST_ACK;
                                end
                                else
                                begin
                                    // data byte: inhibit withholds the ack
                                    ack_reg <= ~sync2_reg[eei_pkg::SYN_WI];
                                    state_reg <= eei_pkg::ST_ACK;
                                end
                            end
                        end
                    end
                    // ninth bit of a received byte: answer, then move on
                    eei_pkg::ST_ACK:
                    begin
                        // ninth rise of an acked write data byte opens the slot
                        if (bit_ev && ack_reg && byte_idx_reg == 2'h3 && !rw_reg)
                            slot_reg <= 1'b1;
                        if (scl_fall)
                        begin
                            if (!ack_phase_reg)
                            begin
                                ack_phase_reg <= 1'b1;
                                SDA_OE_N_O <= ~ack_reg;
                            end
                            else if (ack_reg && byte_idx_reg == 2'h0 && rw_reg)
                            begin
                                // read: first bit goes out on the same fall
                                SDA_OE_N_O <= tx_reg[7];
                                bit_cnt_reg <= eei_pkg::BIT_CNT_RST;
                                state_reg <= eei_pkg::ST_TX;
                            end
                            else
                            begin
                                SDA_OE_N_O <= eei_pkg::OE_N_RST;
                                bit_cnt_reg <= eei_pkg::BIT_CNT_RST;
                                state_reg <= eei_pkg::ST_RX;
                                if (byte_idx_reg != 2'h3)
                                    byte_idx_reg <= byte_idx_reg + 2'h1;
                            end
                        end
                    end
                    // sending: the next bit goes out on each falling clock
                    eei_pkg::ST_TX:
                    begin
                        if (bit_ev)
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (scl_fall)
                        begin
                            if (bit_cnt_reg == eei_pkg::BIT_ACK_SLOT)
                            begin
                                SDA_OE_N_O <= eei_pkg::OE_N_RST;
                                state_reg <= eei_pkg::ST_RXACK;
                            end
                            else if (bit_cnt_reg == eei_pkg::BIT_CNT_RST)
                            begin
                                SDA_OE_N_O <= tx_reg[7];
                            end
                            else
                            begin
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                SDA_OE_N_O <= tx_reg[6];
                            end
                        end
                    end
                    // ninth bit of a sent byte: the master answers
                    eei_pkg::ST_RXACK:
                    begin
                        if (bit_ev)
                        begin
                            // a high level is no answer: stop sending at once
                            if (cap_reg)
                            begin
                                state_reg <= eei_pkg::ST_STANDBY;
                            end
                            else
                            begin
                                tx_reg <= RD_DATA_I;
                                RD_NEXT_O <= 1'b1;
                                bit_cnt_reg <= eei_pkg::BIT_CNT_RST;
                                state_reg <= eei_pkg::ST_TX;
                            end
                        end
                    end
                    // idle: only a start gets out of here
                    eei_pkg::ST_STANDBY:
                    begin
                        SDA_OE_N_O <= eei_pkg::OE_N_RST;
                    end
                    // unused codes fall back to idle
                    default:
                    begin
                        state_reg <= eei_pkg::ST_STANDBY;
                    end
                endcase
            end
        end
    end

    // open drain: the drive value is always low, only the enable moves;
    // reset and enable are kept so the pin is defined from the first edge
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
            SDA_O <= eei_pkg::SDA_LOW;
        else if (CE_I)
            SDA_O <= eei_pkg::SDA_LOW;
    end

    // idle indicator, one cycle behind the state
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
            STANDBY_O <= 1'b1;
        else if (CE_I)
            STANDBY_O <= (state_reg == eei_pkg::ST_STANDBY);
    end
endmodule : eei_slave_front_end

// >>> tb/eei_slave_front_end_properties.sv
`timescale 1ns/1ps
module eei_slave_front_end_properties (
    input wire logic REF_CLK_I, // clock
    input wire logic RESET_I, // reset
    input wire logic SCL_I, // serial clock
    input wire logic SDA_I, // data wire
    input wire logic SDA_O, // drive value
    input wire logic SDA_OE_N_O, // pull enable
    input wire logic WRITE_INHIBIT_I, // inhibit
    input wire logic WR_BUSY_I, // write running
    input wire logic RD_NEXT_O, // byte taken
    input wire eei_pkg::eei_rx_t RX_O, // rx report
    input wire logic WRITE_START_O, // write launch
    input wire logic STANDBY_O // idle
);
    logic sda_q;
    logic stop_ev;
    logic [3:0] since_stop;
    // stop seen as a raw edge, so no sampled function is needed here
    assign stop_ev = SDA_I && !sda_q && SCL_I;
    always_ff @(posedge REF_CLK_I)
    begin
        sda_q <= RESET_I ? 1'b1 : SDA_I;
    end
    // saturates so a long quiet spell never looks like a fresh stop
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I || stop_ev)
            since_stop <= RESET_I ? 4'hf : 4'h0;
        else if (since_stop != 4'hf)
            since_stop <= since_stop + 4'h1;
    end
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RESET_I);
    chk_pin_low: assert property (SDA_O == 1'b0)
        else $error("data drive value not low");
    chk_busy_released: assert property (WR_BUSY_I |-> SDA_OE_N_O)
        else $error("data pulled during write");
    chk_busy_silent: assert property (WR_BUSY_I |-> !RX_O.valid)
        else $error("byte taken during write");
    chk_start_pulse: assert property (WRITE_START_O |=> !WRITE_START_O)
        else $error("write launch longer than one cycle");
    chk_start_cause: assert property (WRITE_START_O |-> since_stop <= 4'h8)
        else $error("write launch without a stop");
    chk_start_inhibit: assert property (WRITE_START_O |-> !WRITE_INHIBIT_I)
        else $error("write launch while inhibited");
    chk_stop_idle: assert property (stop_ev && !WR_BUSY_I |-> ##[1:10] (STANDBY_O || WRITE_START_O))
        else $error("stop not followed by idle");
    chk_idle_released: assert property (STANDBY_O && $past(STANDBY_O) |-> SDA_OE_N_O)
        else $error("data pulled while idle");
    chk_oe_scl_low: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
        else $error("data output moved with clock high");
    chk_rx_pulse: assert property (RX_O.valid |=> !RX_O.valid)
        else $error("byte report longer than one cycle");
    cov_write: cover property (WRITE_START_O);
    cov_read: cover property (RD_NEXT_O);
    cov_ack: cover property ($fell(SDA_OE_N_O));
endmodule : eei_slave_front_end_properties
bind eei_slave_front_end eei_slave_front_end_properties u_props (
    .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .WRITE_INHIBIT_I(WRITE_INHIBIT_I),
    .WR_BUSY_I(WR_BUSY_I), .RD_NEXT_O(RD_NEXT_O), .RX_O(RX_O),
    .WRITE_START_O(WRITE_START_O), .STANDBY_O(STANDBY_O)
);

// >>> tb/eei_i2c_master_model.sv
`timescale 1ns/1ps
// bus master: owns the clock, open drain on data
module eei_i2c_master_model (
    input wire logic sda_i, // resolved data wire
    output logic scl_o, // serial clock
    output logic sda_oe_n_o // low pulls data low
);
    logic tick = 1'b0;
    // 32 ns timebase, phase unrelated to the system clock; 3 ticks a phase
    initial
    begin
        #3;
        forever #16 tick = ~tick;
    end
    // clock stands high between frames
    initial
    begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    // data moves one tick after the clock falls, held across the rise
    task automatic bit_slot(input logic b, output logic r);
        @(posedge tick);
        sda_oe_n_o = b;
        repeat (2) @(posedge tick);
        scl_o = 1'b1;
        repeat (3) @(posedge tick);
        r = sda_i;
        scl_o = 1'b0;
    endtask : bit_slot
    // every instruction opens here, repeated start too
    task automatic start_cond();
        @(posedge tick);
        sda_oe_n_o = 1'b1;
        repeat (2) @(posedge tick);
        scl_o = 1'b1;
        repeat (3) @(posedge tick);
        sda_oe_n_o = 1'b0;
        repeat (3) @(posedge tick);
        scl_o = 1'b0;
    endtask : start_cond
    // data rises with the clock high
    task automatic stop_cond();
        @(posedge tick);
        sda_oe_n_o = 1'b0;
        repeat (2) @(posedge tick);
        scl_o = 1'b1;
        repeat (3) @(posedge tick);
        sda_oe_n_o = 1'b1;
        repeat (3) @(posedge tick);
    endtask : stop_cond
    // msb first, line released in the ninth slot for the answer
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_slot(d[i], r);
        bit_slot(1'b1, r);
        ack = !r;
    endtask : wr_byte
    // receiver side: pull low in the ninth slot only to ask for more
    task automatic rd_byte(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_slot(1'b1, d[i]);
        bit_slot(!give_ack, r);
    endtask : rd_byte
endmodule : eei_i2c_master_model

// >>> tb/eeprom_i2c_slave_front_end_tb_top.sv
`timescale 1ns/1ps
module eeprom_i2c_slave_front_end_tb_top;
    localparam logic [3:0] arr_id = 4'h5; // arbitrary value
    localparam logic [3:0] idp_id = 4'h9; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, m_oe_n, sda, dut_sda, dut_oe_n, rd_next, wstart, stby, a;
    logic [2:0] straps = 3'h0;
    logic wi = 1'b0;
    logic busy = 1'b0;
    logic [7:0] rd_data = 8'hc3;
    logic [7:0] d;
    logic [7:0] sent_q[$];
    eei_pkg::eei_rx_t rx, rx_last;
    int err_count = 0;
    int samples_checked = 0;
    int wstarts = 0;
    int busy_cnt = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    // pull-up wire: low while either party pulls
    assign sda = m_oe_n && dut_oe_n;
    eei_slave_front_end #(.ARRAY_TYPE_ID(arr_id), .IDPAGE_TYPE_ID(idp_id), .IDPAGE_EN(1'b1)) dut (
        .REF_CLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(dut_sda), .SDA_OE_N_O(dut_oe_n), .CHIP_SELECT_STRAP_2_I(straps[2]),
        .CHIP_SELECT_STRAP_1_I(straps[1]), .CHIP_SELECT_STRAP_0_I(straps[0]),
        .WRITE_INHIBIT_I(wi), .WR_BUSY_I(busy), .RD_DATA_I(rd_data), .RD_NEXT_O(rd_next),
        .RX_O(rx), .WRITE_START_O(wstart), .STANDBY_O(stby)
    );
    eei_i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
    // array stand-in: busy for a while after a launch, next byte when one is taken
    always @(negedge clk)
    begin
        if (wstart)
        begin
            wstarts++;
            busy <= 1'b1;
            busy_cnt = 400;
        end
        else if (busy_cnt > 0)
        begin
            busy_cnt--;
            if (busy_cnt == 0)
                busy <= 1'b0;
        end
        if (rd_next)
        begin
            sent_q.push_back(rd_data);
            rd_data <= rd_data + 8'h35;
        end
        if (rx.valid)
            rx_last = rx;
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_byte
    // straps and inhibit pass two synchronising flops, so let them settle
    task automatic set_pins(input logic [2:0] s, input logic w);
        @(negedge clk);
        straps = s;
        wi = w;
        repeat (4) @(negedge clk);
    endtask : set_pins
    task automatic send(input logic [7:0] b, input logic exp_ack);
        m.wr_byte(b, a);
        check_bit(a, exp_ack);
    endtask : send
    task automatic wait_idle(input logic [7:0] n);
        repeat (12) @(negedge clk);
        check_byte(8'(wstarts), n);
    endtask : wait_idle
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        set_pins(3'h5, 1'b0);
        check_bit(stby, 1'b1);
        check_bit(dut_sda, 1'b0);
        m.start_cond();
        send({arr_id, 3'h5, 1'b0}, 1'b1);
        check_byte(rx_last.data, {arr_id, 3'h5, 1'b0});
        send(8'h12, 1'b1);
        check_byte(8'(rx_last.kind), 8'(eei_pkg::KIND_ADDR_HI));
        send(8'h34, 1'b1);
        send(8'ha5, 1'b1);
        check_byte(rx_last.data, 8'ha5);
        check_byte(8'(rx_last.kind), 8'(eei_pkg::KIND_DATA));
        m.stop_cond();
        wait_idle(8'h01);
        m.start_cond();
        send({arr_id, 3'h5, 1'b0}, 1'b0);
        check_bit(stby, 1'b0);
        m.stop_cond();
        wait_idle(8'h01);
        for (int i = 0; i < 1000 && busy; i++)
            @(negedge clk);
        $display("test write and busy done");
        set_pins(3'h5, 1'b1);
        m.start_cond();
        send({arr_id, 3'h5, 1'b0}, 1'b1);
        send(8'h00, 1'b1);
        send(8'h01, 1'b1);
        send(8'h5a, 1'b0);
        m.stop_cond();
        wait_idle(8'h01);
        $display("test inhibit done");
        set_pins(3'h5, 1'b0);
        m.start_cond();
        send({arr_id, 3'h5, 1'b0}, 1'b1);
        send(8'h00, 1'b1);
        m.stop_cond();
        wait_idle(8'h01);
        check_bit(stby, 1'b1);
        $display("test early stop done");
        for (int s = 0; s < 8; s++)
        begin
            set_pins(3'(s), 1'b0);
            m.start_cond();
            send({arr_id, 3'h0, 1'b0}, s == 0);
            send(8'h00, s == 0);
            check_bit(stby, s != 0);
            m.stop_cond();
        end
        wait_idle(8'h01);
        $display("test straps done");
        set_pins(3'h0, 1'b0);
        m.start_cond();
        send({idp_id, 3'h0, 1'b0}, 1'b1);
        check_bit(rx_last.idpage, 1'b1);
        m.start_cond();
        send({4'h3, 3'h0, 1'b0}, 1'b0);
        m.stop_cond();
        $display("test type id done");
        m.start_cond();
        send({arr_id, 3'h0, 1'b1}, 1'b1);
        m.rd_byte(1'b1, d);
        check_byte(d, sent_q[0]);
        m.rd_byte(1'b0, d);
        check_byte(d, sent_q[1]);
        m.stop_cond();
        repeat (12) @(negedge clk);
        check_byte(8'(sent_q.size()), 8'h02);
        check_bit(stby, 1'b1);
        $display("test read done");
        complete_run();
    end
endmodule : eeprom_i2c_slave_front_end_tb_top
